/* jie_defs.svh */
// Purpose: Constants for the jump and increment execution block.
// Assumes: 12-bit instruction words, 8-bit data, 11-bit program counter.
// Notes: Included by both design files.
`ifndef JIE_DEFS_SVH
`define JIE_DEFS_SVH
`define JIE_OP_JUMP 3'h5
`define JIE_OP_INC 6'h0A
`define JIE_OP_INCSKIP 6'h0F
`define JIE_PAGE_HI 6
`define JIE_PAGE_LO 5
`define JIE_ZERO_BIT 2
`define JIE_PC_RESET 11'h7FF
`define JIE_NOP_WORD 12'h000
`endif

/* jie_pkg.sv */
// Purpose: Types for the jump and increment execution block.
// Assumes: Nothing beyond the constants header.
// Notes: Never imported.
package jie_pkg;
    typedef enum logic [1:0] {
        JIE_OTHER,
        JIE_JUMP,
        JIE_INC,
        JIE_INCSKIP
    } jie_op_t;
endpackage

/* jie_decode.sv */
// Purpose: Opcode recognition for the three executed instructions.
// Assumes: Word is stable while decoded.
// Notes: Purely combinational.
`include "jie_defs.svh"
module jie_decode (
    input wire logic [11:0] word_in,
    output jie_pkg::jie_op_t op_out,
    output logic dest_file_out,
    output logic [4:0] addr_out
);
    always_comb begin
        op_out = jie_pkg::JIE_OTHER;
        if (word_in[11:9] == `JIE_OP_JUMP) begin
            op_out = jie_pkg::JIE_JUMP;
        end else if (word_in[11:6] == `JIE_OP_INC) begin
            op_out = jie_pkg::JIE_INC;
        end else if (word_in[11:6] == `JIE_OP_INCSKIP) begin
            op_out = jie_pkg::JIE_INCSKIP;
        end
        dest_file_out = word_in[5];
        addr_out = word_in[4:0];
    end
endmodule // jie_decode

/* jump_and_increment_exec.sv */
// Purpose: Executes jump, increment and increment-skip-if-zero.
// Assumes: File read data for the addressed register is valid in the
//          cycle the instruction executes (combinational read).
// Notes: Other opcodes hold the accumulator and write data but advance the PC and reload status; the fetch uses pc_out.
//
// Overview of operation
// - Top bits 101 load low nine PC bits.
// - Jump takes PC bits 10:9 from status.
// - Jump leaves status flags unchanged.
// - Increment reads file register, adds one.
// - Destination bit picks accumulator or file.
// - Plain increment updates only zero flag.
// - Increment-skip skips next when result zero.
// - Skip discards prefetch, runs no_operation cycle.
// - Increment-skip leaves every status flag alone.
`include "jie_defs.svh"
module jump_and_increment_exec (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic [11:0] instr_in,
    input wire logic [7:0] status_in,
    input wire logic [7:0] file_rdata_in,
    output logic [10:0] pc_out,
    output logic [4:0] file_addr_out,
    output logic [7:0] file_wdata_out,
    output logic file_we_out,
    output logic [7:0] accum_out,
    output logic [7:0] status_out,
    output logic [11:0] exec_word_out
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    jie_pkg::jie_op_t op;
    logic dest_file;
    logic [4:0] addr;
    logic [11:0] word;
    logic skip;
    logic [7:0] sum;
    logic [7:0] operand;
    logic [10:0] pc, next_pc;
    logic [7:0] accum, next_accum, status, next_status;
    logic [7:0] wdata, next_wdata;
    logic we, next_we, next_skip;
    logic [11:0] next_word;

    // A skipped word is replaced here so it never reaches the decoder.
    assign word = skip ? `JIE_NOP_WORD : instr_in;

    jie_decode u_decode (
        .word_in(word),
        .op_out(op),
        .dest_file_out(dest_file),
        .addr_out(addr)
    );

    // ------------------------------------------------------------
    // Operand
    // ------------------------------------------------------------
    // The write-back lands one edge after execution, so a register read
    // back to back would still hold its old value; forward the result.
    always_comb begin
        operand = file_rdata_in;
        if (we && file_addr_out == addr) begin
            operand = wdata;
        end
    end

    assign sum = operand + 8'h01;

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    always_comb begin
        next_pc = pc + 11'h001;
        next_accum = accum;
        next_status = status_in;
        next_wdata = wdata;
        next_we = 1'b0;
        next_skip = 1'b0;
        next_word = word;
        unique case (op)
            jie_pkg::JIE_JUMP: begin
                next_pc = {status_in[`JIE_PAGE_HI:`JIE_PAGE_LO],
                           word[8:0]};
                // Prefetched word after a branch is stale; flush it.
                next_skip = 1'b1;
                next_status = status_in;
            end
            jie_pkg::JIE_INC, jie_pkg::JIE_INCSKIP: begin
                if (dest_file) begin
                    next_wdata = sum;
                    next_we = 1'b1;
                end else begin
                    next_accum = sum;
                end
                if (op == jie_pkg::JIE_INC) begin
                    next_status[`JIE_ZERO_BIT] = (sum == 8'h00);
                end else begin
                    next_skip = (sum == 8'h00);
                end
            end
            jie_pkg::JIE_OTHER: begin
            end
        endcase
    end

    // A low enable holds every register, so a pending skip survives it.
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            pc <= `JIE_PC_RESET;
            accum <= 8'h00;
            status <= 8'h00;
            wdata <= 8'h00;
            we <= 1'b0;
            skip <= 1'b0;
            exec_word_out <= `JIE_NOP_WORD;
            file_addr_out <= 5'h00;
        end else if (clk_en_in) begin
            pc <= next_pc;
            accum <= next_accum;
            status <= next_status;
            wdata <= next_wdata;
            we <= next_we;
            skip <= next_skip;
            exec_word_out <= next_word;
            file_addr_out <= addr;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pc_out = pc;
    assign accum_out = accum;
    assign status_out = status;
    assign file_wdata_out = wdata;
    assign file_we_out = we;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence jie_zero_inc_s;
        clk_en_in && op == jie_pkg::JIE_INCSKIP && sum == 8'h00;
    endsequence

    sequence jie_jump_s;
        clk_en_in && op == jie_pkg::JIE_JUMP;
    endsequence

    sequence jie_skip_pending_s;
        clk_en_in && skip;
    endsequence

    jump_target_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op == jie_pkg::JIE_JUMP |=> pc[8:0] == $past(word[8:0]))
        else $error("jump target low bits wrong");
    jump_page_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op == jie_pkg::JIE_JUMP |=>
        pc[10:9] == $past(status_in[6:5]))
        else $error("jump page bits wrong");
    jump_flags_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op == jie_pkg::JIE_JUMP |=> status == $past(status_in))
        else $error("jump changed status");
    inc_file_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op == jie_pkg::JIE_INC && dest_file |=>
        we && wdata == $past(operand) + 8'h01)
        else $error("increment to file wrong");
    inc_accum_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op != jie_pkg::JIE_OTHER && op != jie_pkg::JIE_JUMP
        && !dest_file |=> !we && accum == $past(sum))
        else $error("increment to accumulator wrong");
    inc_zero_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op == jie_pkg::JIE_INC |=>
        status[2] == ($past(sum) == 8'h00) &&
        status[7:3] == $past(status_in[7:3]))
        else $error("zero flag update wrong");
    skip_nop_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        jie_zero_inc_s |=> skip ##0 (op == jie_pkg::JIE_OTHER))
        else $error("skip not taken");
    skip_flags_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op == jie_pkg::JIE_INCSKIP |=> status == $past(status_in))
        else $error("increment-skip changed status");
    wrap_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        operand == 8'hFF |-> sum == 8'h00)
        else $error("increment did not wrap");
    // The properties below follow a skip from its cause to its no_operation, then check increment-skip write-back and zero flag.
    jump_flush_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        jie_jump_s |=> skip)
        else $error("jump did not flush the next word");
    skip_flush_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        jie_skip_pending_s |=> exec_word_out == `JIE_NOP_WORD && !we &&
        accum == $past(accum))
        else $error("skipped word was executed");
    skip_pc_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        jie_skip_pending_s |=> pc == $past(pc) + 11'h001)
        else $error("no_operation cycle did not advance the counter");
    skip_clear_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op == jie_pkg::JIE_INCSKIP && sum != 8'h00 |=>
        !skip)
        else $error("skip taken on nonzero result");
    skip_file_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        clk_en_in && op == jie_pkg::JIE_INCSKIP && dest_file |=>
        we && wdata == $past(sum))
        else $error("increment-skip write-back wrong");
    skip_zero_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        jie_zero_inc_s |=> status[2] == $past(status_in[2]))
        else $error("increment-skip touched the zero flag");
endmodule // jump_and_increment_exec

/* jie_file_model.sv */
// Purpose: Register file partner with a combinational read port.
// Assumes: Read address is the f field of the word now presented.
// Notes: A write lands on the edge that samples the write strobe.
module jie_file_model (
    input wire logic clk_sys_in,
    input wire logic [4:0] raddr_in,
    input wire logic [4:0] waddr_in,
    input wire logic [7:0] wdata_in,
    input wire logic we_in,
    output logic [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] regs [32];
    assign rdata_out = regs[raddr_in];
    always @(posedge clk_sys_in) begin
        if (we_in) begin
            regs[waddr_in] <= wdata_in;
        end
    end
endmodule // jie_file_model

/* tb_top.sv */
// Purpose: Self-checking bench for jump and increment execution.
// Assumes: One word is presented per cycle.
// Notes: One scenario drops the enable for a few cycles mid-jump.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic [11:0] instr_in = 12'h000;
    logic [7:0] status_in = 8'h00;
    logic [7:0] file_rdata_in, file_wdata_out, accum_out, status_out;
    logic [10:0] pc_out;
    logic [4:0] file_addr_out;
    logic file_we_out;
    logic [11:0] exec_word_out;
    int n_errors = 0;
    int num_checks = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    jump_and_increment_exec u_dut (.clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .instr_in(instr_in), .status_in(status_in),
        .file_rdata_in(file_rdata_in), .pc_out(pc_out),
        .file_addr_out(file_addr_out), .file_wdata_out(file_wdata_out),
        .file_we_out(file_we_out), .accum_out(accum_out),
        .status_out(status_out), .exec_word_out(exec_word_out));
    jie_file_model u_mem (.clk_sys_in(clk_sys_in),
        .raddr_in(instr_in[4:0]), .waddr_in(file_addr_out),
        .wdata_in(file_wdata_out), .we_in(file_we_out),
        .rdata_out(file_rdata_in));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Results of a word are visible once the following word is presented.
    task automatic go(input logic [11:0] w, input logic [7:0] s);
        @(posedge clk_sys_in);
        instr_in <= w;
        status_in <= s;
    endtask
    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic test_jump;
        go(12'hBA5, 8'h44);
        go(12'h283, 8'h44);
        #1;
        check(12'(pc_out), 12'h5A5);
        check(12'(status_out), 12'h044);
        go(12'h000, 8'h44);
        #1;
        check(exec_word_out, 12'h000);
        check(12'(pc_out), 12'h5A6);
        check(12'(accum_out), 12'h000);
    endtask
    task automatic test_inc;
        u_mem.regs[3] = 8'hFF;
        go(12'h283, 8'hA0);
        go(12'h2A5, 8'h04);
        #1;
        check(12'(accum_out), 12'h000);
        check(12'(status_out), 12'h0A4);
        go(12'h000, 8'h00);
        #1;
        check(12'(file_wdata_out), 12'h013);
        check(12'(file_we_out), 12'h001);
        check(12'(file_addr_out), 12'h005);
        check(12'(status_out), 12'h000);
    endtask
    task automatic test_skip;
        go(12'h3E3, 8'h00);
        go(12'h284, 8'h00);
        #1;
        check(12'(file_wdata_out), 12'h000);
        check(12'(status_out), 12'h000);
        go(12'h3C4, 8'h04);
        #1;
        check(exec_word_out, 12'h000);
        check(12'(accum_out), 12'h000);
        go(12'h284, 8'h04);
        #1;
        check(12'(accum_out), 12'h011);
        check(12'(status_out), 12'h004);
        go(12'h000, 8'h00);
        #1;
        check(exec_word_out, 12'h284);
    endtask
    task automatic test_forward;
        go(12'h2A4, 8'h00);
        go(12'h2A4, 8'h00);
        go(12'h284, 8'h00);
        #1;
        check(12'(file_wdata_out), 12'h012);
        check(12'(file_addr_out), 12'h004);
        go(12'h000, 8'h00);
        #1;
        check(12'(accum_out), 12'h013);
        check(12'(file_we_out), 12'h000);
    endtask
    task automatic test_freeze;
        go(12'hBA5, 8'h44);
        go(12'h000, 8'h44);
        clk_en_in <= 1'b0;
        go(12'h284, 8'h00);
        go(12'h284, 8'h00);
        #1;
        check(12'(pc_out), 12'h5A5);
        check(exec_word_out, 12'hBA5);
        check(12'(status_out), 12'h044);
        go(12'h284, 8'h00);
        clk_en_in <= 1'b1;
        go(12'h000, 8'h00);
        #1;
        check(exec_word_out, 12'h000);
        check(12'(pc_out), 12'h5A6);
        check(12'(accum_out), 12'h013);
    endtask
    initial begin
        u_mem.regs[3] = 8'h7F;
        u_mem.regs[4] = 8'h10;
        u_mem.regs[5] = 8'h12;
        repeat (12) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        #1;
        check(12'(pc_out), 12'h7FF);
        test_jump();
        test_inc();
        test_skip();
        test_forward();
        test_freeze();
        end_sim();
    end
    initial begin
        repeat (2000) @(posedge clk_sys_in);
        n_errors++;
        end_sim();
    end
endmodule // tb_top
